// ==== bbu_flow_unit.sv ====
// bbu_flow_unit: program flow and bit manipulation execution
// assumes the fetch unit presents one decoded word with its operands,
// the stack returns popped data before the last cycle of a return
`timescale 1ns/1ps
`default_nettype none
`include "bbu_params.svh"
module bbu_flow_unit (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  input  wire logic        I_INSTR_VALID,
  input  wire logic [15:0] I_INSTR,
  input  wire logic [15:0] I_WORD2,
  input  wire logic        I_NEXT_TWO_WORD,
  input  wire logic [7:0]  I_RD_VAL,
  input  wire logic [7:0]  I_RR_VAL,
  input  wire logic [7:0]  I_IO_VAL,
  input  wire logic [15:0] I_Z,
  input  wire logic [7:0]  I_EXTENDED_INDIRECT_SEGMENT,
  input  wire logic [21:0] I_STACK_DATA,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic      [21:0] O_PC,
  output logic      [7:0]  O_STATUS_FLAGS,
  output logic             O_RES_WE,
  output logic      [4:0]  O_RES_ADDR,
  output logic      [7:0]  O_RES_DATA,
  output logic             O_IO_WE,
  output logic      [4:0]  O_IO_ADDR,
  output logic      [7:0]  O_IO_WDATA,
  output logic             O_PUSH,
  output logic      [21:0] O_PUSH_DATA,
  output logic             O_POP
);

  bbu_pkg::bbu_op_t    dec_op;
  bbu_pkg::bbu_op_t    op_q;
  bbu_pkg::bbu_state_t st_q;
  bbu_pkg::bbu_alu_t   alu_mode;

  logic        accept;
  logic        fin_now;
  logic        fin_late;
  logic        skip;
  logic        br_flag;
  logic        br_hit;
  logic        busy_q;
  logic        done_q;
  logic [2:0]  cyc;
  logic [2:0]  cnt_q;
  logic [2:0]  bsel;
  logic [21:0] pc_q;
  logic [21:0] pc_inc;
  logic [21:0] tgt;
  logic [21:0] tgt_q;
  logic [21:0] br_off;
  logic [21:0] rj_off;
  logic [7:0]  sflags_q;
  logic [7:0]  alu_flags;
  logic [7:0]  alu_res;
  logic [7:0]  alu_b;
  logic [7:0]  bmask;

  // a new word is taken only while idle and enabled
  assign accept = I_INSTR_VALID & ~busy_q & I_CE;
  assign bsel   = I_INSTR[`FLD_BIT];
  assign bmask  = 8'h01 << bsel;
  assign pc_inc = pc_q + 22'h000001;
  assign br_off = {{15{I_INSTR[9]}}, I_INSTR[`FLD_BROFF]};
  assign rj_off = {{10{I_INSTR[11]}}, I_INSTR[`FLD_RJOFF]};
  assign alu_b  = {I_INSTR[11:8], I_INSTR[3:0]};

  // opcode classification; words of other units fall through as other_op
  always_comb begin
    dec_op = bbu_pkg::other_op;
    casez (I_INSTR)
      `OPC_PTR_JUMP:   dec_op = bbu_pkg::pointer_jump_op;
      `OPC_XPTR_JUMP:  dec_op = bbu_pkg::extended_pointer_jump_op;
      `OPC_PTR_CALL:   dec_op = bbu_pkg::pointer_call_op;
      `OPC_XPTR_CALL:  dec_op = bbu_pkg::extended_pointer_call_op;
      `OPC_SUB_RETURN: dec_op = bbu_pkg::subroutine_return_op;
      `OPC_IRQ_RETURN: dec_op = bbu_pkg::interrupt_return_op;
      `OPC_REL_JUMP:   dec_op = bbu_pkg::relative_jump_op;
      `OPC_ABS_JUMP:   dec_op = bbu_pkg::absolute_jump_op;
      `OPC_CMP_SKIP:   dec_op = bbu_pkg::compare_skip_equal_op;
      `OPC_CMP_IMM:    dec_op = bbu_pkg::compare_immediate_op;
      `OPC_RBIT_CLR:   dec_op = bbu_pkg::skip_reg_bit_clear_op;
      `OPC_RBIT_SET:   dec_op = bbu_pkg::skip_reg_bit_set_op;
      `OPC_IOBIT_CLR:  dec_op = bbu_pkg::skip_io_bit_clear_op;
      `OPC_IOBIT_SET:  dec_op = bbu_pkg::skip_io_bit_set_op;
      `OPC_BR_SET:     dec_op = bbu_pkg::branch_flag_set_op;
      `OPC_BR_CLR:     dec_op = bbu_pkg::branch_flag_clear_op;
      `OPC_IO_SET:     dec_op = bbu_pkg::io_bit_set_op;
      `OPC_IO_CLR:     dec_op = bbu_pkg::io_bit_clear_op;
      `OPC_ROTR:       dec_op = bbu_pkg::rotate_right_carry_op;
      `OPC_TO_TFLAG:   dec_op = bbu_pkg::bit_to_transfer_flag_op;
      `OPC_FROM_TFLAG: dec_op = bbu_pkg::transfer_flag_to_bit_op;
      `OPC_SHL: begin
        // only the same-register add is a shift; others belong elsewhere
        if (I_INSTR[8:4] == {I_INSTR[9], I_INSTR[3:0]}) begin
          dec_op = bbu_pkg::shift_left_op;
        end
      end
      `OPC_ROTL: begin
        if (I_INSTR[8:4] == {I_INSTR[9], I_INSTR[3:0]}) begin
          dec_op = bbu_pkg::rotate_left_carry_op;
        end
      end
      default: dec_op = bbu_pkg::other_op;
    endcase
  end

  // branch condition; flag 4 is evaluated as n xor v
  always_comb begin
    if (bsel == 3'(`SR_S)) begin
      br_flag = sflags_q[`SR_N] ^ sflags_q[`SR_V]; // [RL12]
    end else begin
      br_flag = sflags_q[bsel]; // [RL13] [RL14]
    end
    br_hit = br_flag ^ (dec_op == bbu_pkg::branch_flag_clear_op); // [RL11]
  end

  // skip condition of the compare and bit test ops
  always_comb begin
    case (dec_op)
      bbu_pkg::compare_skip_equal_op:
        skip = (I_RD_VAL == I_RR_VAL); // [RL5]
      bbu_pkg::skip_reg_bit_clear_op:
        skip = ~I_RD_VAL[bsel]; // [RL7]
      bbu_pkg::skip_reg_bit_set_op:
        skip = I_RD_VAL[bsel]; // [RL8]
      bbu_pkg::skip_io_bit_clear_op:
        skip = ~I_IO_VAL[bsel]; // [RL9]
      bbu_pkg::skip_io_bit_set_op:
        skip = I_IO_VAL[bsel]; // [RL10]
      default:
        skip = 1'b0;
    endcase
  end

  // cycle count and program counter target per op
  always_comb begin
    cyc = `CYC_ONE;
    tgt = pc_inc;
    case (dec_op)
      bbu_pkg::pointer_jump_op: begin
        cyc = `CYC_PTR_JUMP;
        tgt = {6'h00, I_Z}; // [RL1]
      end
      bbu_pkg::extended_pointer_jump_op: begin
        cyc = `CYC_PTR_JUMP;
        tgt = {I_EXTENDED_INDIRECT_SEGMENT[5:0], I_Z}; // [RL2]
      end
      bbu_pkg::pointer_call_op: begin
        cyc = `CYC_PTR_CALL;
        tgt = {6'h00, I_Z}; // [RL3]
      end
      bbu_pkg::extended_pointer_call_op: begin
        cyc = `CYC_PTR_CALL;
        tgt = {I_EXTENDED_INDIRECT_SEGMENT[5:0], I_Z}; // [RL4]
      end
      bbu_pkg::subroutine_return_op, bbu_pkg::interrupt_return_op: begin
        cyc = `CYC_RETURN; // [RL21]
      end
      bbu_pkg::relative_jump_op: begin
        cyc = `CYC_REL_JUMP;
        tgt = pc_inc + rj_off; // [RL22]
      end
      bbu_pkg::absolute_jump_op: begin
        cyc = `CYC_ABS_JUMP;
        tgt = {I_INSTR[8:4], I_INSTR[0], I_WORD2}; // [RL22]
      end
      bbu_pkg::branch_flag_set_op, bbu_pkg::branch_flag_clear_op: begin
        if (br_hit) begin
          cyc = `CYC_BR_TAKEN;
          tgt = pc_inc + br_off; // [RL11]
        end
      end
      bbu_pkg::io_bit_set_op, bbu_pkg::io_bit_clear_op: begin
        cyc = `CYC_IO_BIT; // [RL15]
      end
      default: begin
        cyc = `CYC_ONE;
      end
    endcase
    // a skipped word costs one cycle per word jumped over
    if (skip) begin
      if (I_NEXT_TWO_WORD) begin
        cyc = `CYC_SKIP_TWO; // [RL5] [RL7] [RL8] [RL9] [RL10]
        tgt = pc_q + 22'h000003;
      end else begin
        cyc = `CYC_SKIP_ONE;
        tgt = pc_q + 22'h000002;
      end
    end
  end

  // alu input selection; only compare, shift and rotate ops commit its flags
  always_comb begin
    case (dec_op)
      bbu_pkg::shift_left_op:         alu_mode = bbu_pkg::alu_shl;
      bbu_pkg::rotate_left_carry_op:  alu_mode = bbu_pkg::alu_rotl;
      bbu_pkg::rotate_right_carry_op: alu_mode = bbu_pkg::alu_rotr;
      default:                        alu_mode = bbu_pkg::alu_sub;
    endcase
  end

  bbu_flag_alu u_alu (
    .i_mode  (alu_mode),
    .i_a     (I_RD_VAL),
    .i_b     (alu_b),
    .i_flags (sflags_q),
    .o_res   (alu_res),
    .o_flags (alu_flags)
  );

  assign fin_now  = accept & (cyc == `CYC_ONE);
  assign fin_late = I_CE & (st_q == bbu_pkg::st_exec) & (cnt_q == 3'h1);

  // sequencer: remaining cycles count down while executing
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q   <= bbu_pkg::st_idle;
      busy_q <= 1'b0;
      cnt_q  <= 3'h0;
      op_q   <= bbu_pkg::other_op;
      tgt_q  <= `PC_RST;
    end else if (I_CE) begin
      if (accept && !fin_now) begin
        st_q   <= bbu_pkg::st_exec;
        busy_q <= 1'b1;
        cnt_q  <= cyc - 3'h1;
        op_q   <= dec_op;
        tgt_q  <= tgt;
      end else if (fin_late) begin
        st_q   <= bbu_pkg::st_idle;
        busy_q <= 1'b0;
        cnt_q  <= 3'h0;
      end else if (st_q == bbu_pkg::st_exec) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  // program counter and completion pulse
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pc_q   <= `PC_RST;
      done_q <= 1'b0;
    end else if (I_CE) begin
      done_q <= fin_now | fin_late;
      if (fin_now) begin
        pc_q <= tgt;
      end else if (fin_late) begin
        if (op_q == bbu_pkg::subroutine_return_op ||
            op_q == bbu_pkg::interrupt_return_op) begin
          pc_q <= I_STACK_DATA; // [RL21]
        end else begin
          pc_q <= tgt_q;
        end
      end
    end
  end

  // status flags; the interrupt return sets enable only as it completes
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sflags_q <= `SR_RST;
    end else if (I_CE) begin
      if (accept) begin
        case (dec_op)
          bbu_pkg::compare_immediate_op,
          bbu_pkg::shift_left_op,
          bbu_pkg::rotate_left_carry_op,
          bbu_pkg::rotate_right_carry_op:
            sflags_q <= alu_flags; // [RL6] [RL16] [RL17] [RL18]
          bbu_pkg::bit_to_transfer_flag_op:
            sflags_q[`SR_T] <= I_RD_VAL[bsel]; // [RL19]
          default: ;
        endcase
      end else if (fin_late && op_q == bbu_pkg::interrupt_return_op) begin
        sflags_q[`SR_I] <= 1'b1; // [RL21]
      end
    end
  end

  // register result write; compare never writes back
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RES_WE   <= 1'b0;
      O_RES_ADDR <= 5'h00;
      O_RES_DATA <= 8'h00;
    end else if (I_CE) begin
      O_RES_WE <= 1'b0;
      if (accept) begin
        O_RES_ADDR <= I_INSTR[`FLD_DST];
        case (dec_op)
          bbu_pkg::shift_left_op,
          bbu_pkg::rotate_left_carry_op,
          bbu_pkg::rotate_right_carry_op: begin
            O_RES_WE   <= 1'b1; // [RL16] [RL17] [RL18]
            O_RES_DATA <= alu_res;
          end
          bbu_pkg::transfer_flag_to_bit_op: begin
            O_RES_WE   <= 1'b1; // [RL20]
            O_RES_DATA <= sflags_q[`SR_T] ? (I_RD_VAL | bmask)
                                          : (I_RD_VAL & ~bmask);
          end
          default: ;
        endcase
      end
    end
  end

  // i/o bit write; the whole byte is written back with one bit changed,
  // so write-one-to-clear flags in the same register get cleared too
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IO_WE    <= 1'b0;
      O_IO_ADDR  <= 5'h00;
      O_IO_WDATA <= 8'h00;
    end else if (I_CE) begin
      O_IO_WE <= 1'b0;
      if (accept) begin
        O_IO_ADDR <= I_INSTR[`FLD_IOA];
        if (dec_op == bbu_pkg::io_bit_set_op) begin
          O_IO_WE    <= 1'b1;
          O_IO_WDATA <= I_IO_VAL | bmask; // [RL15]
        end else if (dec_op == bbu_pkg::io_bit_clear_op) begin
          O_IO_WE    <= 1'b1;
          O_IO_WDATA <= I_IO_VAL & ~bmask; // [RL15]
        end
      end
    end
  end

  // stack requests, one pulse in the cycle after the op is taken
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PUSH      <= 1'b0;
      O_POP       <= 1'b0;
      O_PUSH_DATA <= `PC_RST;
    end else if (I_CE) begin
      O_PUSH <= accept & (dec_op == bbu_pkg::pointer_call_op ||
                          dec_op == bbu_pkg::extended_pointer_call_op);
      O_POP  <= accept & (dec_op == bbu_pkg::subroutine_return_op ||
                          dec_op == bbu_pkg::interrupt_return_op);
      if (accept) begin
        O_PUSH_DATA <= pc_inc; // [RL3] [RL4]
      end
    end
  end

  assign O_BUSY         = busy_q;
  assign O_DONE         = done_q;
  assign O_PC           = pc_q;
  assign O_STATUS_FLAGS = sflags_q;

  // checks assume the enable stays high through an op
  a_ptr_jump: assert property (@(posedge I_CLK) // [RL1]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::pointer_jump_op
    |-> ##1 !O_DONE ##1 O_DONE && O_PC == {6'h00, $past(I_Z, 2)})
    else $error("pointer jump target or timing wrong");

  a_xptr_jump: assert property (@(posedge I_CLK) // [RL2]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::extended_pointer_jump_op
    |-> ##2 O_DONE && O_PC == {$past(I_EXTENDED_INDIRECT_SEGMENT[5:0], 2), $past(I_Z, 2)})
    else $error("extended pointer jump wrong");

  a_ptr_call: assert property (@(posedge I_CLK) // [RL3] [RL4]
    disable iff (!I_RST_N || !I_CE)
    accept && (dec_op == bbu_pkg::pointer_call_op ||
               dec_op == bbu_pkg::extended_pointer_call_op)
    |-> ##1 O_PUSH && O_PUSH_DATA == $past(pc_inc)
    ##1 !O_DONE [*2] ##1 O_DONE && O_PC[15:0] == $past(I_Z, 4))
    else $error("pointer call push or target wrong");

  a_skip_len: assert property (@(posedge I_CLK) // [RL5] [RL7] [RL9]
    disable iff (!I_RST_N || !I_CE)
    accept && skip && I_NEXT_TWO_WORD
    |-> ##3 O_DONE && O_PC == $past(pc_q, 3) + 22'h000003)
    else $error("two word skip wrong");

  a_no_skip: assert property (@(posedge I_CLK) // [RL10]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::skip_io_bit_set_op && !I_IO_VAL[bsel]
    |=> O_DONE && O_PC == $past(pc_inc))
    else $error("untaken skip wrong");

  a_cmp_flags: assert property (@(posedge I_CLK) // [RL6]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::compare_immediate_op
    |=> !O_RES_WE && O_DONE &&
        O_STATUS_FLAGS[`SR_Z] == ($past(I_RD_VAL) == $past(alu_b)) &&
        O_STATUS_FLAGS[`SR_C] == ($past(I_RD_VAL) < $past(alu_b)))
    else $error("compare flags wrong");

  a_branch_take: assert property (@(posedge I_CLK) // [RL11] [RL12]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::branch_flag_clear_op && bsel == 3'h4 &&
    (sflags_q[`SR_N] == sflags_q[`SR_V])
    |-> ##2 O_DONE && O_PC == $past(pc_inc, 2) + $past(br_off, 2))
    else $error("signed branch not taken");

  a_io_bit: assert property (@(posedge I_CLK) // [RL15]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::io_bit_clear_op
    |=> O_IO_WE && !O_IO_WDATA[$past(bsel)] &&
        ((O_IO_WDATA ^ $past(I_IO_VAL)) == $past(I_IO_VAL & bmask))
    ##1 O_DONE && $stable(O_STATUS_FLAGS))
    else $error("i/o bit clear wrong");

  a_shift_res: assert property (@(posedge I_CLK) // [RL16]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::shift_left_op
    |=> O_RES_WE && O_RES_DATA == {$past(I_RD_VAL[6:0]), 1'b0} &&
        O_STATUS_FLAGS[`SR_C] == $past(I_RD_VAL[7]))
    else $error("left shift wrong");

  a_irq_return: assert property (@(posedge I_CLK) // [RL21]
    disable iff (!I_RST_N || !I_CE)
    accept && dec_op == bbu_pkg::interrupt_return_op
    |=> O_POP ##4 O_DONE && O_STATUS_FLAGS[`SR_I])
    else $error("interrupt return wrong");

endmodule // bbu_flow_unit
`default_nettype wire

// ==== bbu_params.svh ====
// bbu_params.svh: constants of the branch and bit instruction unit
// assumes the flow unit and the flag alu include it by bare name
// Notes on behaviour
// [RL1] pointer jump loads pc from the z pair in two cycles
// [RL2] extended pointer jump loads pc from segment joined above z, two cycles
// [RL3] pointer call pushes return address, loads pc from z, four cycles
// [RL4] extended pointer call pushes return address, pc from segment and z
// [RL5] compare-skip skips next when registers equal; 1, 2 or 3 cycles
// [RL6] compare immediate sets z n v c h from rd minus k, no write
// [RL7] skip when register bit clear; 1, 2 or 3 cycles
// [RL8] skip when register bit set; 1, 2 or 3 cycles
// [RL9] skip when i/o bit reads zero; 1, 2 or 3 cycles
// [RL10] skip when i/o bit reads one; 1, 2 or 3 cycles
// [RL11] flag branch taken: pc plus offset plus one in two cycles, else one
// [RL12] signed branches use n xor v as their condition
// [RL13] unsigned branches behave as carry clear and carry set branches
// [RL14] interrupt branches test the global enable flag, one or zero
// [RL15] i/o bit set or clear writes that bit only, two cycles, no flags; here the whole read byte is written back
// [RL16] left shift inserts zero at bit 0, updates z c n v, one cycle
// [RL17] rotate left takes old carry into bit 0, bit 7 into carry
// [RL18] rotate right takes old carry into bit 7, bit 0 into carry
// [RL19] bit store copies selected register bit into transfer flag
// [RL20] bit load copies transfer flag into register bit, flags unchanged
// [RL21] returns pop pc from stack; interrupt return also sets enable flag
// [RL22] relative jump adds offset plus one; absolute jump uses second word
`ifndef BBU_PARAMS_SVH
`define BBU_PARAMS_SVH
`define PC_RST 22'h000000
`define SR_RST 8'h00
`define SR_C 0
`define SR_Z 1
`define SR_N 2
`define SR_V 3
`define SR_S 4
`define SR_H 5
`define SR_T 6
`define SR_I 7
`define FLD_BIT 2:0
`define FLD_DST 8:4
`define FLD_IOA 7:3
`define FLD_BROFF 9:3
`define FLD_RJOFF 11:0
`define CYC_ONE 3'h1
`define CYC_PTR_JUMP 3'h2
`define CYC_REL_JUMP 3'h2
`define CYC_ABS_JUMP 3'h3
`define CYC_PTR_CALL 3'h4
`define CYC_RETURN 3'h5
`define CYC_BR_TAKEN 3'h2
`define CYC_IO_BIT 3'h2
`define CYC_SKIP_ONE 3'h2
`define CYC_SKIP_TWO 3'h3
`define OPC_PTR_JUMP 16'h9409
`define OPC_XPTR_JUMP 16'h9419
`define OPC_PTR_CALL 16'h9509
`define OPC_XPTR_CALL 16'h9519
`define OPC_SUB_RETURN 16'h9508
`define OPC_IRQ_RETURN 16'h9518
`define OPC_REL_JUMP 16'b1100_????_????_????
`define OPC_ABS_JUMP 16'b1001_010?_????_110?
`define OPC_CMP_SKIP 16'b0001_00??_????_????
`define OPC_CMP_IMM 16'b0011_????_????_????
`define OPC_RBIT_CLR 16'b1111_110?_????_0???
`define OPC_RBIT_SET 16'b1111_111?_????_0???
`define OPC_IOBIT_CLR 16'b1001_1001_????_????
`define OPC_IOBIT_SET 16'b1001_1011_????_????
`define OPC_BR_SET 16'b1111_00??_????_????
`define OPC_BR_CLR 16'b1111_01??_????_????
`define OPC_IO_SET 16'b1001_1010_????_????
`define OPC_IO_CLR 16'b1001_1000_????_????
`define OPC_SHL 16'b0000_11??_????_????
`define OPC_ROTL 16'b0001_11??_????_????
`define OPC_ROTR 16'b1001_010?_????_0111
`define OPC_TO_TFLAG 16'b1111_101?_????_0???
`define OPC_FROM_TFLAG 16'b1111_100?_????_0???
`endif

// ==== bbu_pkg.sv ====
// bbu_pkg: types of the branch and bit instruction unit
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package bbu_pkg;
  typedef enum logic [4:0] {
    other_op, pointer_jump_op, extended_pointer_jump_op,
    pointer_call_op, extended_pointer_call_op,
    subroutine_return_op, interrupt_return_op,
    relative_jump_op, absolute_jump_op,
    compare_skip_equal_op, compare_immediate_op,
    skip_reg_bit_clear_op, skip_reg_bit_set_op,
    skip_io_bit_clear_op, skip_io_bit_set_op,
    branch_flag_set_op, branch_flag_clear_op,
    io_bit_set_op, io_bit_clear_op,
    shift_left_op, rotate_left_carry_op, rotate_right_carry_op,
    bit_to_transfer_flag_op, transfer_flag_to_bit_op
  } bbu_op_t;
  typedef enum logic [1:0] {
    alu_sub, alu_shl, alu_rotl, alu_rotr
  } bbu_alu_t;
  typedef enum logic {st_idle, st_exec} bbu_state_t;
endpackage
`default_nettype wire

// ==== bbu_flag_alu.sv ====
// bbu_flag_alu: compare, shift and rotate with status flag update
// assumes the caller selects which ops may commit its flags
`timescale 1ns/1ps
`default_nettype none
`include "bbu_params.svh"
module bbu_flag_alu (
  input  wire bbu_pkg::bbu_alu_t i_mode,
  input  wire logic [7:0]        i_a,
  input  wire logic [7:0]        i_b,
  input  wire logic [7:0]        i_flags,
  output logic      [7:0]        o_res,
  output logic      [7:0]        o_flags
);
  logic [7:0] r;
  logic       n;
  logic       v;
  logic       c;

  // flags not named by an op keep their old value
  always_comb begin
    r = 8'h00;
    c = 1'b0;
    v = 1'b0;
    o_flags = i_flags;
    case (i_mode)
      bbu_pkg::alu_sub: begin
        r = i_a - i_b; // [RL6]
        c = (~i_a[7] & i_b[7]) | (i_b[7] & r[7]) | (r[7] & ~i_a[7]);
        v = (i_a[7] & ~i_b[7] & ~r[7]) | (~i_a[7] & i_b[7] & r[7]);
        o_flags[`SR_H] = (~i_a[3] & i_b[3]) | (i_b[3] & r[3])
                       | (r[3] & ~i_a[3]);
        o_flags[`SR_S] = r[7] ^ v;
      end
      bbu_pkg::alu_shl, bbu_pkg::alu_rotl: begin
        // zero in for a shift, old carry in for a rotate
        r = {i_a[6:0], (i_mode == bbu_pkg::alu_rotl) & i_flags[`SR_C]};
        c = i_a[7]; // [RL16] [RL17]
        v = r[7] ^ c;
      end
      default: begin
        r = {i_flags[`SR_C], i_a[7:1]}; // [RL18]
        c = i_a[0];
        v = r[7] ^ c;
      end
    endcase
    n = r[7];
    o_flags[`SR_C] = c;
    o_flags[`SR_Z] = (r == 8'h00);
    o_flags[`SR_N] = n;
    o_flags[`SR_V] = v;
    o_res = r;
  end
endmodule // bbu_flag_alu
`default_nettype wire

// ==== testbench.sv ====
// testbench: random and corner runs of the flow and bit unit
// assumes registered outputs settle well before each falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst_n, vld, nxt, busy, done, rwe, iwe, push, pop;
  logic [15:0] ins, w2, z, op;
  logic [7:0]  rd, rr, io, extended_indirect_segment, fl, rdat, iwd, fl_e, res_e, pul_e, pul;
  logic [21:0] stk, pc, pushd, pc_e, ret;
  logic [4:0]  radr, iadr, d;
  logic [2:0]  b;
  logic [31:0] rnd, r1, r2;
  logic        sk, tk, set, rchk, ichk;
  int          bad_count, total_checks, cyc, i, n_e, n, nb;

  bbu_flow_unit DUT (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_INSTR_VALID(vld),
    .I_INSTR(ins), .I_WORD2(w2), .I_NEXT_TWO_WORD(nxt), .I_RD_VAL(rd),
    .I_RR_VAL(rr), .I_IO_VAL(io), .I_Z(z), .I_EXTENDED_INDIRECT_SEGMENT(extended_indirect_segment),
    .I_STACK_DATA(stk), .O_BUSY(busy), .O_DONE(done), .O_PC(pc),
    .O_STATUS_FLAGS(fl), .O_RES_WE(rwe), .O_RES_ADDR(radr),
    .O_RES_DATA(rdat), .O_IO_WE(iwe), .O_IO_ADDR(iadr),
    .O_IO_WDATA(iwd), .O_PUSH(push), .O_PUSH_DATA(pushd), .O_POP(pop));

  // clock at 100 ns; the cycle ceiling cuts a hung handshake short
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // flags of a minus b; transfer and enable flags pass through
  function automatic logic [7:0] f_sub(input logic [7:0] a, k, o);
    logic [7:0] r;
    logic       v, c, h;
    r = a - k;
    v = (a[7] & ~k[7] & ~r[7]) | (~a[7] & k[7] & r[7]);
    c = (~a[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~a[7]);
    h = (~a[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~a[3]);
    return {o[7:6], h, r[7] ^ v, v, r[7], r == 8'h00, c};
  endfunction

  // shift flags: overflow is n xor c, sign and half stay put
  function automatic logic [7:0] f_sh(input logic [7:0] r, o, input c);
    return {o[7:4], r[7] ^ c, r[7], r == 8'h00, c};
  endfunction

  // one op from the falling edge; pulses counted two bits per kind
  task automatic run(input logic [15:0] o);
    ins = o;
    vld = 1'b1;
    pul = 8'h00;
    n = 0;
    nb = 0;
    // valid stays up after a one-cycle op so the next call can reuse it
    do begin
      @(negedge clk);
      if (done !== 1'b1) vld = 1'b0;
      n++;
      nb += busy;
      pul = pul + {1'b0, pop, 1'b0, push, 1'b0, iwe, 1'b0, rwe};
    end while (done !== 1'b1 && n < 8);
    chk("cycles", n, n_e);
    chk("pc", pc, pc_e);
    chk("flags", fl, fl_e);
    chk("pulses", pul, pul_e);
    chk("busy", nb, n_e - 1);
  endtask

  initial begin
    {vld, nxt, ins, w2, z, rd, rr, io, extended_indirect_segment, stk} = '0;
    rst_n = 1'b0;
    rnd = 32'd75697;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("pc reset", pc, 22'h000000);
    chk("flags reset", fl, 8'h00);
    pc_e = 22'h000000;
    fl_e = 8'h00;
    for (i = 0; i < 500; i++) begin
      rnd = nx(rnd);
      r1 = rnd;
      rnd = nx(rnd);
      r2 = rnd;
      rnd = nx(rnd);
      // equal operands half the time; each input is written once per step
      if (rnd[23]) r1[23:16] = r1[31:24];
      // overflow and most negative offset corners now and then
      if (i % 16 == 0) {r1[31:24], r1[15:8], r2[6:0]} = {8'h80, 8'h01, 7'h40};
      {rd, rr, io, extended_indirect_segment} = r1;
      {z, w2} = r2;
      stk = rnd[21:0];
      nxt = rnd[22];
      set = rnd[28];
      b = rnd[31:29];
      d = w2[4:0];
      {rchk, ichk, sk} = 3'b000;
      pul_e = 8'h00;
      n_e = 1;
      ret = pc_e + 22'h1;
      pc_e = ret;
      case (rnd[27:24])
        4'h0: {op, n_e, pc_e} = {16'h9409, 32'd2, 6'h00, z};
        4'h1: {op, n_e, pc_e} = {16'h9419, 32'd2, extended_indirect_segment[5:0], z};
        4'h2, 4'h3: begin
          {op, n_e, pul_e} = {16'h9509, 32'd4, 8'h10};
          pc_e = {6'h00, z};
          if (rnd[24]) {op, pc_e} = {16'h9519, extended_indirect_segment[5:0], z};
        end
        4'h4: begin
          {op, n_e, pul_e, pc_e} = {16'h9508, 32'd5, 8'h40, stk};
          if (set) {op[4], fl_e[7]} = 2'b11;
        end
        4'h5: begin
          {op, n_e} = {4'hc, w2[11:0], 32'd2};
          pc_e = ret + {{10{w2[11]}}, w2[11:0]};
        end
        4'h6: begin
          {op, n_e} = {7'b1001010, rd[4:0], 3'b110, rd[5], 32'd3};
          pc_e = {rd[4:0], rd[5], w2};
        end
        4'h7: begin
          op = {4'h3, io[7:4], rnd[31:28], io[3:0]};
          fl_e = f_sub(rd, io, fl_e);
        end
        4'h8: {op, sk} = {6'h04, w2[9:0], rd == rr};
        4'h9: {op, sk} = {7'h7e, d, 1'b0, b, ~rd[b]};
        4'ha: {op, sk} = {7'h7f, d, 1'b0, b, rd[b]};
        4'hb: {op, sk} = {8'h99, d, b, ~io[b]};
        4'hc: {op, sk} = {8'h9b, d, b, io[b]};
        4'hd: begin
          op = {5'b11110, ~set, w2[6:0], b};
          tk = (b == 3'h4) ? fl_e[2] ^ fl_e[3] : fl_e[b];
          tk = set ? tk : ~tk;
          n_e = tk ? 2 : 1;
          if (tk) pc_e = ret + {{15{w2[6]}}, w2[6:0]};
        end
        4'he: begin
          {op, n_e, pul_e, ichk} = {6'h26, set, 1'b0, d, b, 32'd2, 8'h04, 1'b1};
          res_e = io & ~(8'h01 << b);
          res_e[b] = set;
        end
        default: begin
          {rchk, pul_e} = {1'b1, 8'h01};
          case (w2[15:14])
            2'h0: begin
              op = {6'h03, d[4], d, d[3:0]};
              res_e = {rd[6:0], 1'b0};
              fl_e = f_sh(res_e, fl_e, rd[7]);
            end
            2'h1: begin
              op = {6'h07, d[4], d, d[3:0]};
              res_e = {rd[6:0], fl_e[0]};
              fl_e = f_sh(res_e, fl_e, rd[7]);
            end
            2'h2: begin
              op = {7'b1001010, d, 4'h7};
              res_e = {fl_e[0], rd[7:1]};
              fl_e = f_sh(res_e, fl_e, rd[0]);
            end
            default: begin
              {op, res_e} = {7'h7c, d, 1'b0, b, rd};
              res_e[b] = fl_e[6];
              if (w2[13]) begin
                {op[9], rchk, pul_e} = {2'b10, 8'h00}; // bit store
                fl_e[6] = rd[b];
              end
            end
          endcase
        end
      endcase
      if (sk) {n_e, pc_e} = {nxt ? 32'd3 : 32'd2, ret + (nxt ? 22'h2 : 22'h1)};
      run(op);
      if (pul_e[5:4] != 2'h0) chk("push data", pushd, ret);
      if (rchk) chk("result", {radr, rdat}, {d, res_e});
      if (ichk) chk("io write", {iadr, iwd}, {d, res_e});
    end
    results();
  end
endmodule // testbench
`default_nettype wire
